// [pkg/pmucal_map.svh]
// Register offsets, field positions and reset values of the MEASURE_CHANNEL calibration bank
`ifndef PMUCAL_MAP_SVH
`define PMUCAL_MAP_SVH

// Register offsets on the plain register port
`define PMUCAL_ADDR_SYSCTL 8'h00
`define PMUCAL_ADDR_ALARM 8'h01
`define PMUCAL_ADDR_COMP 8'h02
`define PMUCAL_ADDR_IRQ_STAT 8'h03
`define PMUCAL_ADDR_IRQ_CLR 8'h04
`define PMUCAL_ADDR_IRQ_EN 8'h05
`define PMUCAL_ADDR_CFG_BASE 8'h10
// DAC space: addr[7:6] is the register type code, addr[5:0] the DAC select
`define PMUCAL_TYPE_GAIN 2'h1
`define PMUCAL_TYPE_OFS 2'h2
`define PMUCAL_TYPE_X1 2'h3

// Readback word fields
`define PMUCAL_RB_TYPE_MSB 23
`define PMUCAL_RB_TYPE_LSB 22
`define PMUCAL_RB_ADDR_MSB 21
`define PMUCAL_RB_ADDR_LSB 16

// DAC select layout: {channel[1:0], kind[2:0], voltage_or_current}
`define PMUCAL_KIND_LEVEL 3'h0
`define PMUCAL_KIND_CLAMP_LO 3'h1
`define PMUCAL_KIND_CLAMP_HI 3'h2
`define PMUCAL_KIND_CMP_LO 3'h3
`define PMUCAL_KIND_CMP_HI 3'h4
`define PMUCAL_OFFSET_DAC_SEL 6'h0F
`define PMUCAL_NUM_KINDS 5

// Channel configuration field positions
`define PMUCAL_CFG_CHAN_ON 21
`define PMUCAL_CFG_DRIVE_HIGH 20
`define PMUCAL_CFG_DRIVE_LOW 19
`define PMUCAL_CFG_CMP_VI 7

// Reset values
`define PMUCAL_RST_GAIN 16'hFFFF
`define PMUCAL_RST_OFS 16'h8000
`define PMUCAL_RST_OFFSET_DAC 16'hA492
`define PMUCAL_RST_LEVEL 16'h8000
`define PMUCAL_RST_LOW 16'h0000
`define PMUCAL_RST_HIGH 16'hFFFF
`define PMUCAL_RST_ALARM 24'hFF_FFF0
`define PMUCAL_RST_COMP 24'h40_0000
`define PMUCAL_RST_SYSCTL 22'h00_0020
`define PMUCAL_RST_CFG 22'h01_E060

// Correction midscale and saturation
`define PMUCAL_MIDSCALE 19'h0_8000
`define PMUCAL_FULLSCALE 19'h0_FFFF

// Interrupt status bits
`define PMUCAL_IRQ_CACHED 0
`define PMUCAL_IRQ_LOADED 1
`define PMUCAL_IRQ_CFG 2
`define PMUCAL_IRQ_BADADDR 3
`define PMUCAL_IRQ_W 4

`endif

// [pkg/pmucal_pkg.sv]
// Types shared by the MEASURE_CHANNEL calibration register bank
package pmucal_pkg;

   // Drive type held in the channel configuration
   typedef enum logic [1:0] {
      PMUCAL_FV = 2'h0,
      PMUCAL_FI = 2'h1,
      PMUCAL_HZV = 2'h2,
      PMUCAL_HZI = 2'h3
   } pmucal_drive_t;

   // One channel's five live DAC levels
   typedef struct packed {
      logic [15:0] level;
      logic [15:0] clamp_lo;
      logic [15:0] clamp_hi;
      logic [15:0] cmp_lo;
      logic [15:0] cmp_hi;
   } pmucal_dacs_t;

   // A finished correction on its way to the cache
   typedef struct packed {
      logic valid;
      logic [5:0] sel;
      logic [15:0] code;
   } pmucal_cal_t;

endpackage : pmucal_pkg

// [hdl/pmucal_top.sv]
// Calibration register bank and DAC load control for a four-channel MEASURE_CHANNEL
// How it works
// - DAC readback gives a 24-bit word: type code, DAC select and data.
// - Bits 23:22 of readback: 01 gain, 10 offset, 11 input code.
// - Readback bits 21:16 hold the DAC select, bits 15:0 the register data.
// - Gain coefficients reset to 0xFFFF, offset coefficients to 0x8000.
// - Alarm status resets to 0xFFFFF0, comparator status to 0x400000.
// - Input codes reset: offset 0xA492, level 0x8000, lower 0x0000, upper 0xFFFF.
// - System control resets to zero except thermal sensor enable at bit 5.
// - Channel config resets with bits 16,15,14,13,6,5 set, others clear.
// - All channel and DAC registers start from a fixed reset store.
// - Each input code write computes and caches a corrected code.
// - A config write sets switches and loads DACs from cached codes.
// - Codes for unselected modes are cached but leave DAC outputs alone.
// - Separate code and cache registers per voltage and current range.
// - Drive type bits 20:19 select high-Z modes, opening the output switch.
// - In high-Z modes level and clamp code writes for the range in use load immediately.
// - While forcing voltage, current clamp code writes load immediately.
// Limitations
// Gain and offset writes do not redo the cache; rewrite the input code after them.
// One current range per DAC: each select has a voltage half and a current half.
// Alarm and comparator status hold power-on values; their sources sit outside.
// Correction scales by (gain + 1) / 65536 and moves by offset minus midscale.
// Results saturate at both ends of the code range rather than wrapping.
// Reads of unmapped space return zero and raise the bad address event.
// Both strobes at once are not supported; the master never drives that.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "pmucal_map.svh"

module pmucal_top
   import pmucal_pkg::*;
#(
   parameter int NCH = 4
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [23:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [23:0] reg_rdata_out,
   // Analog side controls
   output pmucal_dacs_t [NCH-1:0] dac_level_out,
   output logic [15:0] offset_dac_out,
   output logic [NCH-1:0][21:0] channel_cfg_out,
   output logic [NCH-1:0] output_switch_out,
   output logic [21:0] system_control_out,
   // Interrupt
   output logic irq_out
);

   // DAC select layout: {channel, kind, voltage_or_current}
   // Kinds 5..7 are unmapped, except select 0x0F, which is the offset DAC.
   // Every select gets storage so that decode stays a plain index;
   // the unused entries simply hold their reset values forever.
   // Area was traded for a decode with no holes to test.
   localparam int NENT = 64;

   // Storage and control state
   logic [15:0] gain_r [NENT];
   logic [15:0] ofs_r [NENT];
   logic [15:0] x1_r [NENT];
   logic [15:0] x2_r [NENT];
   logic [21:0] sysctl_r;
   logic [21:0] cfg_r [NCH];
   logic [23:0] alarm_r;
   logic [23:0] comp_r;
   logic [`PMUCAL_IRQ_W-1:0] irq_stat_r;
   logic [`PMUCAL_IRQ_W-1:0] irq_en_r;
   logic [23:0] rdata_r;
   pmucal_cal_t cal_r;
   pmucal_dacs_t [NCH-1:0] dacs_r;
   logic [15:0] offset_dac_r;

   // Decoded strobes
   logic dac_space;
   logic dac_sel_ok;
   logic [5:0] dac_sel;
   logic [1:0] dac_type;
   logic x1_wr;
   logic cfg_space;
   logic [1:0] cfg_ch;
   logic addr_ok;
   logic [15:0] x1_of_cal;
   logic [NCH-1:0] loaded_now;
   logic [NCH-1:0] cfg_wr;
   logic offset_load;
   logic [18:0] cal_sum;
   logic [32:0] cal_prod;
   logic [15:0] cal_code;

   // Reset store: default input code for each DAC select
   function automatic logic [15:0] x1_default(input logic [5:0] sel);
      logic [2:0] kind;
      kind = sel[3:1];
      if (sel == `PMUCAL_OFFSET_DAC_SEL) begin
         x1_default = `PMUCAL_RST_OFFSET_DAC;
      end else if (kind == `PMUCAL_KIND_LEVEL) begin
         x1_default = `PMUCAL_RST_LEVEL;
      end else if (kind == `PMUCAL_KIND_CLAMP_LO || kind == `PMUCAL_KIND_CMP_LO) begin
         x1_default = `PMUCAL_RST_LOW;
      end else if (kind == `PMUCAL_KIND_CLAMP_HI || kind == `PMUCAL_KIND_CMP_HI) begin
         x1_default = `PMUCAL_RST_HIGH;
      end else begin
         x1_default = 16'h0000;
      end
   endfunction : x1_default

   // Range half (0 voltage, 1 current) that a config selects for a DAC kind
   function automatic logic sel_vi(input logic [21:0] cfg, input int kind);
      logic cur;
      cur = cfg[`PMUCAL_CFG_DRIVE_LOW];
      if (kind == 0) begin
         sel_vi = cur;
      end else if (kind < 3) begin
         sel_vi = ~cur;
      end else begin
         sel_vi = cfg[`PMUCAL_CFG_CMP_VI];
      end
   endfunction : sel_vi

   // Address decode; type code 00 is never DAC space
   assign dac_type = reg_addr_in[7:6];
   assign dac_sel = reg_addr_in[5:0];
   assign dac_space = (dac_type != 2'h0);
   assign dac_sel_ok = (dac_sel[3:1] < 3'(`PMUCAL_NUM_KINDS)) || (dac_sel == `PMUCAL_OFFSET_DAC_SEL);
   assign x1_wr = reg_wr_in && dac_space && dac_sel_ok && (dac_type == `PMUCAL_TYPE_X1);
   assign cfg_space = (reg_addr_in[7:2] == `PMUCAL_ADDR_CFG_BASE >> 2);
   assign cfg_ch = reg_addr_in[1:0];
   assign addr_ok = (dac_space && dac_sel_ok) || cfg_space ||
      (reg_addr_in <= `PMUCAL_ADDR_IRQ_EN);

   // Gain and offset correction, saturated to the code range
   // Reads the stored input code, so it must run one cycle after the write.
   // Adding one to the gain makes 0xFFFF a unit gain, matching the reset store.
   // Wide product keeps the top bits so saturation sees real overflow.
   assign x1_of_cal = x1_r[cal_r.sel];
   assign cal_prod = {17'h0_0000, x1_of_cal} * {16'h0000, 17'({1'b0, gain_r[cal_r.sel]} + 17'h0_0001)};
   assign cal_sum = 19'(cal_prod[32:16]) + {3'h0, ofs_r[cal_r.sel]};
   always_comb begin
      if (cal_sum < `PMUCAL_MIDSCALE) begin
         cal_code = 16'h0000;
      end else if (cal_sum - `PMUCAL_MIDSCALE > `PMUCAL_FULLSCALE) begin
         cal_code = 16'hFFFF;
      end else begin
         cal_code = 16'(cal_sum - `PMUCAL_MIDSCALE);
      end
   end

   // Correction runs the cycle after the code write; a write in that cycle lands at the same edge as its result
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cal_r <= '0;
      end else begin
         cal_r.valid <= x1_wr;
         cal_r.sel <= dac_sel;
         cal_r.code <= 16'h0000;
      end
   end

   // Coefficient, input code and cache storage, one set per DAC select and range
   // Unmapped selects never write, so their entries stay at reset.
   // Type code 00 never reaches here; dac_space screens it out.
   for (genvar e = 0; e < NENT; e++) begin : g_ent
      always_ff @(posedge clk_in or negedge nrst_in) begin
         if (!nrst_in) begin
            gain_r[e] <= `PMUCAL_RST_GAIN;
            ofs_r[e] <= `PMUCAL_RST_OFS;
            x1_r[e] <= x1_default(6'(e));
         end else if (reg_wr_in && dac_space && dac_sel == 6'(e) && dac_sel_ok) begin
            unique case (dac_type)
               `PMUCAL_TYPE_GAIN: gain_r[e] <= reg_wdata_in[15:0];
               `PMUCAL_TYPE_OFS: ofs_r[e] <= reg_wdata_in[15:0];
               default: x1_r[e] <= reg_wdata_in[15:0];
            endcase
         end
      end
      // Cache: unit gain and zero offset leave the default codes unchanged
      always_ff @(posedge clk_in or negedge nrst_in) begin
         if (!nrst_in) begin
            x2_r[e] <= x1_default(6'(e));
         end else if (cal_r.valid && cal_r.sel == 6'(e)) begin
            x2_r[e] <= cal_code;
         end
      end
   end

   // System control, with the thermal sensor enable set at reset
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sysctl_r <= `PMUCAL_RST_SYSCTL;
      end else if (reg_wr_in && reg_addr_in == `PMUCAL_ADDR_SYSCTL) begin
         sysctl_r <= reg_wdata_in[21:0];
      end
   end

   // Alarm and comparator status hold their power-on values; their sources lie outside
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         alarm_r <= `PMUCAL_RST_ALARM;
         comp_r <= `PMUCAL_RST_COMP;
      end
   end

   // Offset DAC has no mode, so every correction of it loads at once
   // It shares the cache path, so its cached copy also follows each write.
   assign offset_load = cal_r.valid && cal_r.sel == `PMUCAL_OFFSET_DAC_SEL;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         offset_dac_r <= `PMUCAL_RST_OFFSET_DAC;
      end else if (offset_load) begin
         offset_dac_r <= cal_code;
      end
   end

   // Per channel: configuration, switches and live DAC levels
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      // One bit per DAC kind: a correction landing on the range in use
      logic [`PMUCAL_NUM_KINDS-1:0] hit;
      assign cfg_wr[c] = reg_wr_in && cfg_space && cfg_ch == 2'(c);

      always_ff @(posedge clk_in or negedge nrst_in) begin
         if (!nrst_in) begin
            cfg_r[c] <= `PMUCAL_RST_CFG;
         end else if (cfg_wr[c]) begin
            cfg_r[c] <= reg_wdata_in[21:0];
         end
      end

      // High-Z drive types open the force amplifier switch
      assign output_switch_out[c] = cfg_r[c][`PMUCAL_CFG_CHAN_ON] &&
         !cfg_r[c][`PMUCAL_CFG_DRIVE_HIGH];
      assign channel_cfg_out[c] = cfg_r[c];

      for (genvar k = 0; k < `PMUCAL_NUM_KINDS; k++) begin : g_kind
         logic [5:0] sel_cur;
         logic [5:0] sel_new;
         logic [15:0] cached;
         // sel_cur follows the mode already held; sel_new the mode being written.
         // A config write must pick its cache entry from the incoming mode,
         // otherwise the DAC would load the range the channel is leaving.
         assign sel_cur = {2'(c), 3'(k), sel_vi(cfg_r[c], k)};
         assign sel_new = {2'(c), 3'(k), sel_vi(reg_wdata_in[21:0], k)};
         // A correction ending in this cycle is newer than the cache
         assign cached = (cal_r.valid && cal_r.sel == sel_new) ? cal_code : x2_r[sel_new];
         // Only the range the present mode uses reaches the DAC; covers high-Z and clamps
         assign hit[k] = cal_r.valid && cal_r.sel == sel_cur;

         always_ff @(posedge clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
               dacs_r[c][16*(4-k) +: 16] <= x1_default({2'(c), 3'(k), sel_vi(`PMUCAL_RST_CFG, k)});
            end else if (cfg_wr[c]) begin
               dacs_r[c][16*(4-k) +: 16] <= cached;
            end else if (hit[k]) begin
               dacs_r[c][16*(4-k) +: 16] <= cal_code;
            end
         end
      end
      assign loaded_now[c] = |hit;
   end

   // Sticky events; a new event beats a clear in the same cycle
   // Bits: 0 cached, 1 loaded, 2 config written, 3 bad address.
   // Set wins so that an event is never lost to a clear racing it.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= (irq_stat_r &
            ~((reg_wr_in && reg_addr_in == `PMUCAL_ADDR_IRQ_CLR) ?
            reg_wdata_in[`PMUCAL_IRQ_W-1:0] : '0)) |
            {(reg_wr_in || reg_rd_in) && !addr_ok, |cfg_wr,
            (|loaded_now) || offset_load, cal_r.valid};
      end
   end

   // Interrupt enables
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_en_r <= '0;
      end else if (reg_wr_in && reg_addr_in == `PMUCAL_ADDR_IRQ_EN) begin
         irq_en_r <= reg_wdata_in[`PMUCAL_IRQ_W-1:0];
      end
   end

   // Read data, valid in the cycle after the strobe only
   // Cleared when idle so stale data never looks like a fresh answer.
   // Upper bits of narrow registers read as zero.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_r <= '0;
      end else if (!reg_rd_in) begin
         rdata_r <= '0;
      end else if (dac_space) begin
         if (!dac_sel_ok) begin
            rdata_r <= '0;
         end else begin
            unique case (dac_type)
               `PMUCAL_TYPE_GAIN: rdata_r <= {dac_type, dac_sel, gain_r[dac_sel]};
               `PMUCAL_TYPE_OFS: rdata_r <= {dac_type, dac_sel, ofs_r[dac_sel]};
               default: rdata_r <= {dac_type, dac_sel, x1_r[dac_sel]};
            endcase
         end
      end else if (cfg_space) begin
         rdata_r <= {2'h0, cfg_r[cfg_ch]};
      end else begin
         unique case (reg_addr_in)
            `PMUCAL_ADDR_SYSCTL: rdata_r <= {2'h0, sysctl_r};
            `PMUCAL_ADDR_ALARM: rdata_r <= alarm_r;
            `PMUCAL_ADDR_COMP: rdata_r <= comp_r;
            `PMUCAL_ADDR_IRQ_STAT: rdata_r <= 24'({irq_stat_r});
            `PMUCAL_ADDR_IRQ_EN: rdata_r <= 24'({irq_en_r});
            default: rdata_r <= '0;
         endcase
      end
   end

   // Outputs
   // Data outputs come straight from flip-flops; only the interrupt
   // and the switch controls are combinational.
   assign reg_rdata_out = rdata_r;
   assign dac_level_out = dacs_r;
   assign offset_dac_out = offset_dac_r;
   assign system_control_out = sysctl_r;
   assign irq_out = |(irq_stat_r & irq_en_r);

endmodule : pmucal_top

// [verif/pmucal_host_model.sv]
// Host controller model driving the plain register port
`timescale 1ns/1ps

module pmucal_host_model (
   // Clock and read data
   input wire logic clk_in,
   input wire logic [23:0] reg_rdata_in,
   // Request lines
   output logic [7:0] reg_addr_out,
   output logic [23:0] reg_wdata_out,
   output logic reg_wr_out,
   output logic reg_rd_out
);
   // Idle bus at time zero
   initial begin
      reg_addr_out = 8'h00;
      reg_wdata_out = 24'h00_0000;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
   end

   // One-cycle write; data inverted after so stale data never looks valid
   task automatic write_reg(input logic [7:0] a, input logic [23:0] d);
      @(posedge clk_in);
      reg_addr_out <= a;
      reg_wdata_out <= d;
      reg_wr_out <= 1'b1;
      @(posedge clk_in);
      reg_wr_out <= 1'b0;
      reg_wdata_out <= ~d;
   endtask : write_reg

   // One-cycle read; data stands only in the following cycle
   task automatic read_reg(input logic [7:0] a, output logic [23:0] d);
      @(posedge clk_in);
      reg_addr_out <= a;
      reg_rd_out <= 1'b1;
      @(posedge clk_in);
      reg_rd_out <= 1'b0;
      #1 d = reg_rdata_in;
   endtask : read_reg
endmodule : pmucal_host_model

// [verif/pmucal_properties.sv]
// Port-level checker for the MEASURE_CHANNEL calibration register bank
`timescale 1ns/1ps

module pmucal_checker
   import pmucal_pkg::*;
#(
   parameter int NCH = 4
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [23:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [23:0] reg_rdata_out,
   // Analog side controls
   input wire pmucal_dacs_t [NCH-1:0] dac_level_out,
   input wire logic [15:0] offset_dac_out,
   input wire logic [NCH-1:0][21:0] channel_cfg_out,
   input wire logic [NCH-1:0] output_switch_out,
   input wire logic [21:0] system_control_out,
   input wire logic irq_out
);
   logic dac_ok;
   logic [NCH-1:0] sw_exp;

   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   // Mapped DAC space only; kinds 5..7 besides the offset DAC read as zero
   assign dac_ok = (reg_addr_in[7:6] != 2'h0) &&
                   ((reg_addr_in[3:1] < 3'h5) || (reg_addr_in[5:0] == 6'h0F));

   // Switch closed only while on and not high-Z
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         sw_exp[i] = channel_cfg_out[i][21] & ~channel_cfg_out[i][20];
      end
   end

   chk_type_code: assert property (
      reg_rd_in && dac_ok |=> reg_rdata_out[23:22] == $past(reg_addr_in[7:6]))
      else $error("readback type code wrong");
   chk_select_field: assert property (
      reg_rd_in && dac_ok |=> reg_rdata_out[21:16] == $past(reg_addr_in[5:0]))
      else $error("readback select field wrong");
   chk_no_type_zero: assert property (
      reg_rd_in && dac_ok |=> reg_rdata_out[23:22] != 2'h0)
      else $error("readback type code zero");
   chk_switch_open: assert property (
      output_switch_out == sw_exp)
      else $error("output switch state wrong");
   chk_cfg_write: assert property (
      reg_wr_in && reg_addr_in == 8'h10 |=> channel_cfg_out[0] == $past(reg_wdata_in[21:0]))
      else $error("config write not taken");
   chk_unused_code: assert property (
      reg_wr_in && reg_addr_in[7:1] == 7'h60 && reg_addr_in[0] != channel_cfg_out[0][19]
      ##1 !reg_wr_in |=> $stable(dac_level_out[0].level))
      else $error("unselected code moved the level output");
   chk_reset_values: assert property (
      $rose(nrst_in) |-> system_control_out == 22'h00_0020 &&
      channel_cfg_out[0] == 22'h01_E060 && offset_dac_out == 16'hA492)
      else $error("reset values wrong");
   chk_alarm_const: assert property (
      reg_rd_in && reg_addr_in == 8'h01 |=> reg_rdata_out == 24'hFF_FFF0)
      else $error("alarm status read wrong");
endmodule : pmucal_checker

bind pmucal_top pmucal_checker #(.NCH(NCH)) u_chk (.clk_in(clk_in), .nrst_in(nrst_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .dac_level_out(dac_level_out),
   .offset_dac_out(offset_dac_out), .channel_cfg_out(channel_cfg_out),
   .output_switch_out(output_switch_out), .system_control_out(system_control_out),
   .irq_out(irq_out));

// [verif/testbench.sv]
// Self-checking bench for the MEASURE_CHANNEL calibration register bank
`timescale 1ns/1ps

module testbench;
   import pmucal_pkg::*;
   logic clk_in, nrst_in, wr, rd, irq;
   logic [7:0] addr;
   logic [23:0] wdata, rdata, rd_d;
   pmucal_dacs_t [3:0] dac_level;
   logic [15:0] offset_dac;
   logic [3:0][21:0] cfg;
   logic [3:0] sw;
   logic [21:0] sysctl;
   logic [15:0] xexp [5];
   int error_cnt, tests_run, cyc;

   pmucal_top #(.NCH(4)) DUT (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .dac_level_out(dac_level), .offset_dac_out(offset_dac), .channel_cfg_out(cfg),
      .output_switch_out(sw), .system_control_out(sysctl), .irq_out(irq));
   pmucal_host_model host (.clk_in(clk_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
      .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd));

   // Correction with saturation at both ends of the code range
   function automatic logic [15:0] cal_code(input logic [15:0] x, g, o);
      logic [35:0] p;
      p = {20'h0, x} * ({20'h0, g} + 36'h1);
      p = (p >> 16) + {20'h0, o};
      if (p < 36'h8000) return 16'h0000;
      p = p - 36'h8000;
      return (p > 36'hFFFF) ? 16'hFFFF : p[15:0];
   endfunction : cal_code

   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic rd_chk(input logic [7:0] a, input logic [23:0] exp);
      host.read_reg(a, rd_d);
      check(rd_d, exp);
   endtask : rd_chk

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   // 25 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   // Hang guard, well above the few hundred cycles the run needs
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         print_verdict();
      end
   end

   // Main sequence
   initial begin
      nrst_in = 1'b0;
      xexp = '{16'h8000, 16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF};
      repeat (8) @(posedge clk_in);
      nrst_in <= 1'b1;
      @(posedge clk_in);
      #1 check({8'h00, offset_dac}, 24'h00_A492);
      check({8'h00, dac_level[2].clamp_hi}, 24'h00_FFFF);
      rd_chk(8'h00, 24'h00_0020);
      rd_chk(8'h13, 24'h01_E060);
      rd_chk(8'h01, 24'hFF_FFF0);
      rd_chk(8'h02, 24'h40_0000);
      rd_chk(8'hCF, 24'hCF_A492);
      for (int s = 0; s < 64; s++) begin
         if (s[3:1] < 3'h5) begin
            rd_chk({2'b01, s[5:0]}, {2'b01, s[5:0], 16'hFFFF});
            rd_chk({2'b10, s[5:0]}, {2'b10, s[5:0], 16'h8000});
            rd_chk({2'b11, s[5:0]}, {2'b11, s[5:0], xexp[s[3:1]]});
         end
      end
      // Host bring-up order, then high-Z preload
      host.write_reg(8'h00, 24'h00_0120);
      rd_chk(8'h00, 24'h00_0120);
      check({2'h0, sysctl}, 24'h00_0120);
      host.write_reg(8'h10, 24'h31_E060);
      #1 check({23'h0, sw[0]}, 24'h00_0000);
      host.write_reg(8'h40, 24'h00_7FFF);
      host.write_reg(8'h80, 24'h00_8100);
      host.write_reg(8'hC0, 24'h00_4000);
      @(posedge clk_in);
      #1 check(dac_level[0].level, cal_code(16'h4000, 16'h7FFF, 16'h8100));
      rd_chk(8'hC0, 24'hC0_4000);
      // Code for the unselected range only reaches the cache
      host.write_reg(8'hC1, 24'h00_1234);
      @(posedge clk_in);
      #1 check(dac_level[0].level, cal_code(16'h4000, 16'h7FFF, 16'h8100));
      host.write_reg(8'h10, 24'h29_E060);
      #1 check(dac_level[0].level, cal_code(16'h1234, 16'hFFFF, 16'h8000));
      check({23'h0, sw[0]}, 24'h00_0001);
      host.write_reg(8'h10, 24'h21_E060);
      #1 check(dac_level[0].level, cal_code(16'h4000, 16'h7FFF, 16'h8100));
      host.write_reg(8'hC5, 24'h00_7000);
      @(posedge clk_in);
      #1 check(dac_level[0].clamp_hi, cal_code(16'h7000, 16'hFFFF, 16'h8000));
      // Offset DAC loads on every correction of its code
      host.write_reg(8'hCF, 24'h00_1000);
      @(posedge clk_in);
      #1 check({8'h00, offset_dac}, {8'h00, cal_code(16'h1000, 16'hFFFF, 16'h8000)});
      // Interrupt: enable, clear, bad address, mask
      host.write_reg(8'h05, 24'h00_0004);
      #1 check({23'h0, irq}, 24'h00_0001);
      host.write_reg(8'h04, 24'h00_000F);
      #1 check({23'h0, irq}, 24'h00_0000);
      rd_chk(8'h06, 24'h00_0000);
      check({23'h0, irq}, 24'h00_0000);
      host.write_reg(8'h05, 24'h00_0008);
      #1 check({23'h0, irq}, 24'h00_0001);
      host.write_reg(8'h04, 24'h00_0008);
      #1 check({23'h0, irq}, 24'h00_0000);
      print_verdict();
   end
endmodule : testbench
